// File: core/sslcp_cfg.svh
`ifndef SSLCP_CFG_SVH
`define SSLCP_CFG_SVH

// register byte offsets on the bus
`define SSLCP_OFS_CMD 8'h00
`define SSLCP_OFS_DATA 8'h04

// command word field positions
`define SSLCP_BIT_IGNORE 31
`define SSLCP_BIT_WRITE 15
`define SSLCP_BIT_ROM 14
`define SSLCP_BIT_REQ 13
`define SSLCP_BIT_XCHG 12
`define SSLCP_BIT_SS 11

// start/stop type patterns on bits 11..8
`define SSLCP_SS_STOP 4'h8
`define SSLCP_SS_START 4'h9
`define SSLCP_SS_SETUP 4'hF
`define SSLCP_GLOBAL_HALT 16'h0800
`define SSLCP_CMD_IDLE 16'h0000

// local parameter table; type, revision and core codes are arbitrary values
`define SSLCP_PAR_TYPE 8'h5A
`define SSLCP_PAR_WIDTH 8'h08
`define SSLCP_PAR_MAJOR 8'h01
`define SSLCP_PAR_MINOR 8'h00
`define SSLCP_PAR_GPIN 8'h00
`define SSLCP_PAR_GPOUT 8'h00
`define SSLCP_PAR_CORE 8'hA5
`define SSLCP_PAR_CHANS 8'h08
`define SSLCP_PAR_SCRATCH 4'h8

// internal processing time of one command
`define SSLCP_CLK_NS 10
`define SSLCP_PROC_NS 50
`define SSLCP_PROC_CYC ((`SSLCP_PROC_NS + `SSLCP_CLK_NS - 1) / `SSLCP_CLK_NS)

// bus answers
`define SSLCP_RESP_OKAY 2'h0
`define SSLCP_RESP_SLVERR 2'h2

`endif

// File: core/sslcp_pkg.sv
package sslcp_pkg;

    // register write request from the bus slave
    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } sslcp_regwr_t;

    // one-cycle channel operation issued by the command decoder
    typedef struct packed {
        logic halt;
        logic stop;
        logic start;
        logic setup;
        logic xchg;
        logic [7:0] mask;
    } sslcp_chop_t;

    typedef enum logic {SSLCP_IDLE, SSLCP_BUSY} sslcp_st_t;

    typedef struct packed {
        logic awHeld;
        logic wHeld;
        logic [7:0] addr;
        logic [31:0] wdata;
        logic [3:0] strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } sslcp_axil_t;

    typedef struct packed {
        logic [7:0] running;
        logic [7:0] setup;
        logic [7:0] faultHist;
        logic [7:0] failMask;
    } sslcp_track_t;

    typedef struct packed {
        sslcp_st_t st;
        logic [15:0] cmd;
        logic [7:0] data;
        logic [3:0] cnt;
        logic romEn;
        logic cpuRst;
        logic linkRst;
        logic xchg;
        logic [7:0] xchgMask;
        sslcp_chop_t op;
        logic [7:0] presA;
        logic [7:0] presB;
        logic [7:0] faultA;
        logic [7:0] faultB;
        logic [7:0][7:0] scratch;
    } sslcp_top_t;

endpackage

// File: core/sslcp_axil_slave.sv
`timescale 1ns/1ps
`include "sslcp_cfg.svh"
module sslcp_axil_slave (
    input logic clk,                          // system clock
    input logic rst,                          // synchronous reset
    input logic [7:0] s_axi_awaddr,           // write address
    input logic s_axi_awvalid,                // write address valid
    output logic s_axi_awready,               // write address ready
    input logic [31:0] s_axi_wdata,           // write data
    input logic [3:0] s_axi_wstrb,            // write byte lanes
    input logic s_axi_wvalid,                 // write data valid
    output logic s_axi_wready,                // write data ready
    output logic [1:0] s_axi_bresp,           // write response
    output logic s_axi_bvalid,                // write response valid
    input logic s_axi_bready,                 // write response ready
    input logic [7:0] s_axi_araddr,           // read address
    input logic s_axi_arvalid,                // read address valid
    output logic s_axi_arready,               // read address ready
    output logic [31:0] s_axi_rdata,          // read data
    output logic [1:0] s_axi_rresp,           // read response
    output logic s_axi_rvalid,                // read data valid
    input logic s_axi_rready,                 // read data ready
    output sslcp_pkg::sslcp_regwr_t regWr,    // register write, one cycle
    input logic wrOk,                         // write address is mapped
    input logic [31:0] rdData,                // read data for s_axi_araddr
    input logic rdOk                          // read address is mapped
);
    sslcp_pkg::sslcp_axil_t s_r;
    sslcp_pkg::sslcp_axil_t s_nxt;

    // channel readiness and register-side request
    assign s_axi_awready = !s_r.awHeld && !s_r.bvalid;
    assign s_axi_wready = !s_r.wHeld && !s_r.bvalid;
    assign s_axi_arready = !s_r.rvalid;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;
    assign regWr = '{en: s_r.awHeld && s_r.wHeld, addr: s_r.addr, data: s_r.wdata, strb: s_r.strb};

    // address and data are taken in either order, the write fires once both are held
    always_comb
    begin
        s_nxt = s_r;
        if (s_axi_awvalid && s_axi_awready)
        begin
            s_nxt.awHeld = 1'b1;
            s_nxt.addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            s_nxt.wHeld = 1'b1;
            s_nxt.wdata = s_axi_wdata;
            s_nxt.strb = s_axi_wstrb;
        end
        if (regWr.en)
        begin
            s_nxt.awHeld = 1'b0;
            s_nxt.wHeld = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = wrOk ? `SSLCP_RESP_OKAY : `SSLCP_RESP_SLVERR;
        end
        if (s_r.bvalid && s_axi_bready)
            s_nxt.bvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = rdOk ? rdData : 32'h0000_0000;
            s_nxt.rresp = rdOk ? `SSLCP_RESP_OKAY : `SSLCP_RESP_SLVERR;
        end
        else if (s_r.rvalid && s_axi_rready)
            s_nxt.rvalid = 1'b0;
    end

    // state register
    always_ff @(posedge clk)
    begin
        if (rst)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end
endmodule

// File: core/sslcp_chan_track.sv
`timescale 1ns/1ps
module sslcp_chan_track (
    input logic clk,                          // system clock
    input logic rst,                          // synchronous reset
    input sslcp_pkg::sslcp_chop_t op,         // channel operation pulse
    input logic [7:0] present,                // synchronised remote presence
    input logic [7:0] fault,                  // synchronised remote fault
    output logic [7:0] running,               // channel is started
    output logic [7:0] setupMode,             // channel started in setup mode
    output logic [7:0] failMask               // per-channel failure of last op
);
    sslcp_pkg::sslcp_track_t s_r;
    sslcp_pkg::sslcp_track_t s_nxt;
    logic [7:0] runN;
    logic [7:0] setN;
    logic [7:0] histN;
    logic [7:0] failN;

    // per-channel reaction to the operation
    generate
        for (genvar i = 0; i < 8; i++)
        begin : g_chan
            wire sel = op.mask[i];
            wire startHit = op.start && sel;
            wire xchgHit = op.xchg && sel;
            wire xchgBad = !s_r.running[i] || fault[i];
            assign runN[i] = op.halt ? 1'b0 : (op.stop && sel) ? 1'b0 : startHit ? present[i] : s_r.running[i];
            assign setN[i] = op.halt ? 1'b0 : startHit ? op.setup : s_r.setup[i];
            assign failN[i] = (startHit && !present[i]) || (xchgHit && xchgBad);
            assign histN[i] = op.halt ? 1'b0 : (s_r.faultHist[i] || failN[i]);
        end
    endgenerate

    // a new failure mask is latched by every operation
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.running = runN;
        s_nxt.setup = setN;
        s_nxt.faultHist = histN;
        if (op.halt || op.stop || op.start || op.xchg)
            s_nxt.failMask = failN;
    end

    // state register
    always_ff @(posedge clk)
    begin
        if (rst)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign running = s_r.running;
    assign setupMode = s_r.setup;
    assign failMask = s_r.failMask;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // checks of channel bookkeeping
    stop_keeps_hist_a: assert property (op.stop && !op.halt |=> s_r.faultHist == $past(s_r.faultHist))
        else $error("per-channel stop changed channel variables");
    start_fail_a: assert property (op.start |=> failMask == ($past(op.mask) & ~$past(present)))
        else $error("start failure mask wrong");
endmodule

// File: core/sslcp_top.sv
// Summary of operation
// - 16-bit command, low half of word
// - bit 15 flags a parameter write
// - bit 14 resets processor, enables loading
// - bit 13 requests local parameter access
// - bit 12 requests process-data exchange
// - bits 11..8: stop, start, setup start
// - low byte selects the channels
// - command starts when written
// - completion clears command register to zero
// - busy command register reads last command
// - global stop accepted anytime, resets link
// - writes with bit 31 set ignored
// - 8-bit data register, low byte
// - read: request, poll zero, read data
// - write: poll zero, data, request+write
// - stop with empty mask halts all
// - per-channel stop keeps channel variables
// - data holds per-channel failure mask
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "sslcp_cfg.svh"
module sslcp_top (
    input logic clk,                          // 100 MHz system clock
    input logic rst,                          // synchronous reset, active high
    input logic [7:0] s_axi_awaddr,           // write address
    input logic s_axi_awvalid,                // write address valid
    output logic s_axi_awready,               // write address ready
    input logic [31:0] s_axi_wdata,           // write data
    input logic [3:0] s_axi_wstrb,            // write byte lanes
    input logic s_axi_wvalid,                 // write data valid
    output logic s_axi_wready,                // write data ready
    output logic [1:0] s_axi_bresp,           // write response
    output logic s_axi_bvalid,                // write response valid
    input logic s_axi_bready,                 // write response ready
    input logic [7:0] s_axi_araddr,           // read address
    input logic s_axi_arvalid,                // read address valid
    output logic s_axi_arready,               // read address ready
    output logic [31:0] s_axi_rdata,          // read data
    output logic [1:0] s_axi_rresp,           // read response
    output logic s_axi_rvalid,                // read data valid
    input logic s_axi_rready,                 // read data ready
    input logic [7:0] remotePresent,          // remote device answers, pin
    input logic [7:0] remoteFault,            // remote device fault, pin
    output logic [7:0] chanRunning,           // started channels
    output logic [7:0] chanSetup,             // channels in setup mode
    output logic xchgStrobe,                  // exchange request pulse
    output logic [7:0] xchgMask,              // channels of the exchange
    output logic linkReset,                   // link interface reset pulse
    output logic cpuReset,                    // interface processor reset pulse
    output logic romLoadEn,                   // program store load enable
    output logic cmdBusy                      // command in progress
);
    sslcp_pkg::sslcp_top_t s_r;
    sslcp_pkg::sslcp_top_t s_nxt;
    sslcp_pkg::sslcp_regwr_t regWr;
    logic wrOk;
    logic rdOk;
    logic [31:0] rdData;
    logic [7:0] failMask;
    logic cmdWr;
    logic ignoreWr;
    logic haltWr;
    logic accWr;
    logic [15:0] newCmd;
    logic [3:0] ssType;
    logic [7:0] parRead;
    logic [3:0] parAddr;
    logic parInRange;

    sslcp_axil_slave u_bus (
        .clk(clk),
        .rst(rst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .regWr(regWr),
        .wrOk(wrOk),
        .rdData(rdData),
        .rdOk(rdOk)
    );

    sslcp_chan_track u_track (
        .clk(clk),
        .rst(rst),
        .op(s_r.op),
        .present(s_r.presB),
        .fault(s_r.faultB),
        .running(chanRunning),
        .setupMode(chanSetup),
        .failMask(failMask)
    );

    // register read decode, command in the low half and data in the low byte
    always_comb
    begin
        rdOk = (s_axi_araddr == `SSLCP_OFS_CMD) || (s_axi_araddr == `SSLCP_OFS_DATA);
        wrOk = (regWr.addr == `SSLCP_OFS_CMD) || (regWr.addr == `SSLCP_OFS_DATA);
        if (s_axi_araddr == `SSLCP_OFS_CMD)
            rdData = {16'h0000, s_r.cmd};
        else if (s_axi_araddr == `SSLCP_OFS_DATA)
            rdData = {24'h00_0000, s_r.data};
        else
            rdData = 32'h0000_0000;
    end

    // command write qualification
    // both low lanes must be written, and the ignore flag counts only with its lane
    assign newCmd = regWr.data[15:0];
    assign cmdWr = regWr.en && (regWr.addr == `SSLCP_OFS_CMD) && (regWr.strb[1:0] == 2'h3);
    assign ignoreWr = regWr.strb[3] && regWr.data[`SSLCP_BIT_IGNORE];
    assign haltWr = cmdWr && !ignoreWr && (newCmd == `SSLCP_GLOBAL_HALT);
    assign accWr = cmdWr && !ignoreWr && (s_r.st == sslcp_pkg::SSLCP_IDLE || haltWr);
    assign ssType = newCmd[`SSLCP_BIT_SS:`SSLCP_BIT_SS - 3];

    // local parameter lookup, low half read-only, upper half scratch
    // an address with bits above the table set reads as zero
    assign parAddr = s_r.cmd[3:0];
    assign parInRange = (s_r.cmd[12:4] == 9'h000);
    always_comb
    begin
        unique case (parAddr)
            4'h0: parRead = `SSLCP_PAR_TYPE;
            4'h1: parRead = `SSLCP_PAR_WIDTH;
            4'h2: parRead = `SSLCP_PAR_MAJOR;
            4'h3: parRead = `SSLCP_PAR_MINOR;
            4'h4: parRead = `SSLCP_PAR_GPIN;
            4'h5: parRead = `SSLCP_PAR_GPOUT;
            4'h6: parRead = `SSLCP_PAR_CORE;
            4'h7: parRead = `SSLCP_PAR_CHANS;
            default: parRead = s_r.scratch[parAddr[2:0]];
        endcase
    end

    // command sequencer
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.op = '0;
        s_nxt.cpuRst = 1'b0;
        s_nxt.linkRst = 1'b0;
        s_nxt.xchg = 1'b0;
        // remote pins pass two flip-flops before the channel logic sees them
        s_nxt.presA = remotePresent;
        s_nxt.presB = s_r.presA;
        s_nxt.faultA = remoteFault;
        s_nxt.faultB = s_r.faultA;
        if (regWr.en && regWr.addr == `SSLCP_OFS_DATA && regWr.strb[0])
            s_nxt.data = regWr.data[7:0];
        // completion comes after the host data write so the result byte wins
        unique case (s_r.st)
            sslcp_pkg::SSLCP_IDLE:
            begin
                s_nxt.cnt = 4'(`SSLCP_PROC_CYC);
            end
            sslcp_pkg::SSLCP_BUSY:
            begin
                if (s_r.cnt != 4'h0)
                    s_nxt.cnt = s_r.cnt - 4'h1;
                else
                begin
                    s_nxt.st = sslcp_pkg::SSLCP_IDLE;
                    s_nxt.cmd = `SSLCP_CMD_IDLE;
                    s_nxt.romEn = 1'b0;
                    if (s_r.cmd[`SSLCP_BIT_REQ] && !s_r.cmd[`SSLCP_BIT_WRITE])
                        s_nxt.data = parInRange ? parRead : 8'h00;
                    else if (s_r.cmd[`SSLCP_BIT_REQ] && parInRange && parAddr >= `SSLCP_PAR_SCRATCH)
                        s_nxt.scratch[parAddr[2:0]] = s_r.data;
                    else if (s_r.cmd[`SSLCP_BIT_XCHG] || s_r.cmd[`SSLCP_BIT_SS])
                        s_nxt.data = failMask;
                end
            end
        endcase
        // accepted write starts at once, a global stop also aborts the current one
        if (accWr)
        begin
            s_nxt.st = sslcp_pkg::SSLCP_BUSY;
            s_nxt.cmd = newCmd;
            s_nxt.cnt = 4'(`SSLCP_PROC_CYC);
            if (newCmd[`SSLCP_BIT_ROM])
            begin
                s_nxt.cpuRst = 1'b1;
                s_nxt.romEn = 1'b1;
            end
            else if (newCmd[`SSLCP_BIT_REQ])
                s_nxt.op = '0;
            else if (newCmd[`SSLCP_BIT_SS])
            begin
                s_nxt.op.mask = newCmd[7:0];
                s_nxt.op.halt = haltWr;
                s_nxt.linkRst = haltWr;
                s_nxt.op.stop = (ssType == `SSLCP_SS_STOP) && !haltWr;
                s_nxt.op.start = (ssType == `SSLCP_SS_START) || (ssType == `SSLCP_SS_SETUP);
                s_nxt.op.setup = (ssType == `SSLCP_SS_SETUP);
            end
            else if (newCmd[`SSLCP_BIT_XCHG])
            begin
                s_nxt.op.xchg = 1'b1;
                s_nxt.op.mask = newCmd[7:0];
                s_nxt.xchg = 1'b1;
                s_nxt.xchgMask = newCmd[7:0];
            end
        end
    end

    // state register
    always_ff @(posedge clk)
    begin
        if (rst)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    // link-side outputs
    // pulses last one clock, the load enable stands until completion
    assign xchgStrobe = s_r.xchg;
    assign xchgMask = s_r.xchgMask;
    assign linkReset = s_r.linkRst;
    assign cpuReset = s_r.cpuRst;
    assign romLoadEn = s_r.romEn;
    assign cmdBusy = (s_r.st == sslcp_pkg::SSLCP_BUSY);

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // command register behaviour
    cmd_upper_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == `SSLCP_OFS_CMD
        |=> s_axi_rdata[31:16] == 16'h0000)
        else $error("command read has upper bits set");
    ignore_wr_a: assert property (cmdWr && ignoreWr && !(cmdBusy && s_r.cnt == 4'h0)
        |=> s_r.cmd == $past(s_r.cmd))
        else $error("ignored command write changed register");
    start_now_a: assert property (cmdWr && !ignoreWr && !cmdBusy |=> cmdBusy && s_r.cmd == $past(newCmd))
        else $error("command did not start on write");
    done_zero_a: assert property (cmdBusy && s_r.cnt == 4'h0 && !accWr |=> !cmdBusy && s_r.cmd == 16'h0000)
        else $error("completed command not cleared");
    busy_hold_a: assert property (cmdBusy && s_r.cnt != 4'h0 && !haltWr |=> $stable(s_r.cmd))
        else $error("busy command word changed");
    busy_bound_a: assert property ($rose(cmdBusy) |-> ##[1:7] !cmdBusy || $past(accWr))
        else $error("command took too long");
    halt_any_a: assert property (haltWr |=> s_r.op.halt && linkReset && s_r.cmd == 16'h0800)
        else $error("global stop not taken");
    rom_rst_a: assert property (accWr && newCmd[14] |=> cpuReset && romLoadEn)
        else $error("processor reset missing");
    xchg_pulse_a: assert property (accWr && newCmd[15:11] == 5'h02 |=> xchgStrobe ##1 !xchgStrobe)
        else $error("exchange strobe wrong");
    reset_idle_a: assert property ($past(rst) |-> s_r.cmd == 16'h0000 && !cmdBusy)
        else $error("command register not idle after reset");
    par_read_a: assert property (cmdBusy && s_r.cnt == 4'h0 && !accWr && s_r.cmd[15:13] == 3'h1 && parInRange
        |=> s_r.data == $past(parRead))
        else $error("parameter read wrong");

    // data register behaviour
    data_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == `SSLCP_OFS_DATA
        |=> s_axi_rdata == {24'h00_0000, $past(s_r.data)})
        else $error("data read wrong");

    data_write_a: assert property (regWr.en && regWr.addr == `SSLCP_OFS_DATA && regWr.strb[0]
        && !(cmdBusy && s_r.cnt == 4'h0) |=> s_r.data == $past(regWr.data[7:0]))
        else $error("data write lost");

    par_write_a: assert property (cmdBusy && s_r.cnt == 4'h0 && !accWr && s_r.cmd[15:13] == 3'h5
        && parInRange && parAddr[3] |=> s_r.scratch[$past(parAddr[2:0])] == $past(s_r.data))
        else $error("parameter write lost");

    fail_data_a: assert property (cmdBusy && s_r.cnt == 4'h0 && !accWr && !s_r.cmd[13]
        && (s_r.cmd[12] || s_r.cmd[11]) |=> s_r.data == $past(failMask))
        else $error("failure mask not in data");

    // decode of the command kinds
    stop_type_a: assert property (accWr && newCmd[15:8] == 8'h08 && newCmd[7:0] != 8'h00
        |=> s_r.op.stop && !s_r.op.halt && !linkReset)
        else $error("per-channel stop decoded wrong");

    setup_type_a: assert property (accWr && newCmd[15:8] == 8'h0F
        |=> s_r.op.start && s_r.op.setup && s_r.op.mask == $past(newCmd[7:0]))
        else $error("setup start decoded wrong");

    req_no_op_a: assert property (accWr && newCmd[13] && !newCmd[14] |=> s_r.op == '0 && !xchgStrobe)
        else $error("parameter access touched channels");

    rom_end_a: assert property (cmdBusy && s_r.cnt == 4'h0 && !accWr |=> !romLoadEn)
        else $error("load enable outlived command");

    cover_start_c: cover property (accWr && newCmd[15:8] == 8'h09 ##[1:7] !cmdBusy);
    cover_halt_busy_c: cover property (cmdBusy && haltWr);
    cover_par_write_c: cover property (accWr && newCmd[15:13] == 3'h5);
    cover_par_read_c: cover property (accWr && newCmd[15:13] == 3'h1);
    cover_ignore_c: cover property (cmdWr && ignoreWr);
endmodule

// File: dv/tb_serial_link_command_port.sv
`timescale 1ns/1ps
`include "sslcp_cfg.svh"
module tb_serial_link_command_port;
    logic clk = 1'b0, rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic awready, wready, bvalid, arready, rvalid, xchgStrobe, linkReset, cpuReset, romLoadEn, cmdBusy;
    logic [1:0] bresp, rresp, resp;
    logic [7:0] chanRunning, chanSetup, xchgMask, lastMask;
    int mismatches = 0, check_count = 0, xchgCnt = 0, linkCnt = 0, cpuCnt = 0;
    // clock at 100 MHz
    always #5 clk = ~clk;
    sslcp_top u_dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .remotePresent(8'h0F),
        .remoteFault(8'h02), .chanRunning(chanRunning), .chanSetup(chanSetup), .xchgStrobe(xchgStrobe),
        .xchgMask(xchgMask), .linkReset(linkReset), .cpuReset(cpuReset), .romLoadEn(romLoadEn),
        .cmdBusy(cmdBusy));
    // count the one-cycle pulses of the block
    always @(posedge clk)
    begin
        if (xchgStrobe === 1'b1) xchgCnt++;
        if (xchgStrobe === 1'b1) lastMask <= xchgMask;
        if (linkReset === 1'b1) linkCnt++;
        if (cpuReset === 1'b1) cpuCnt++;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    // bus write; ready sampled at the falling edge, so the handshake edge is known in advance
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic ah, wh, bh;
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do
        begin
            @(negedge clk);
            ah = awvalid & awready; wh = wvalid & wready; bh = bvalid; resp = bresp;
            @(posedge clk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            n++;
        end while (bh !== 1'b1 && n < 50);
        bready <= 1'b0;
        if (n >= 50) mismatches++;
    endtask
    // bus read, data and response taken at the edge where rvalid is seen
    task rdr(input logic [7:0] a);
        logic ah, rh;
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do
        begin
            @(negedge clk);
            ah = arvalid & arready; rh = rvalid; rd = rdata; resp = rresp;
            @(posedge clk);
            if (ah) arvalid <= 1'b0;
            n++;
        end while (rh !== 1'b1 && n < 50);
        rready <= 1'b0;
        if (n >= 50) mismatches++;
    endtask
    // poll the command register until it reads idle
    task poll();
        int n;
        n = 0;
        do
        begin
            rdr(`SSLCP_OFS_CMD);
            n++;
        end while (rd !== 32'h0 && n < 40);
        chk(rd, 32'h0, "command not cleared");
    endtask
    task results();
        $display("comparisons %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // watchdog against a hung handshake
    initial
    begin
        #100000;
        mismatches++;
        results();
    end
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rdr(`SSLCP_OFS_CMD);
        chk(rd, 32'h0, "command after reset");
        chk(32'(resp), 32'(`SSLCP_RESP_OKAY), "mapped read response");
        rdr(`SSLCP_OFS_DATA);
        chk(rd, 32'h0, "data after reset");
        rdr(8'h08);
        chk(32'(resp), 32'(`SSLCP_RESP_SLVERR), "unmapped read response");
        wr(8'h08, 32'h0000_0001);
        chk(32'(resp), 32'(`SSLCP_RESP_SLVERR), "unmapped write response");
        $display("test reset done");
        wr(`SSLCP_OFS_CMD, 32'h0001_2001);
        chk(32'(resp), 32'(`SSLCP_RESP_OKAY), "command write response");
        chk(32'(cmdBusy), 32'h1, "busy after command write");
        rdr(`SSLCP_OFS_CMD);
        chk(rd, 32'h0000_2001, "command readback while busy");
        poll();
        rdr(`SSLCP_OFS_DATA);
        chk(rd, 32'(`SSLCP_PAR_WIDTH), "parameter read");
        wr(`SSLCP_OFS_DATA, 32'h0000_003C);
        wr(`SSLCP_OFS_CMD, 32'h0000_A008);
        poll();
        wr(`SSLCP_OFS_CMD, 32'h0000_2008);
        poll();
        rdr(`SSLCP_OFS_DATA);
        chk(rd, 32'h0000_003C, "parameter write readback");
        wr(`SSLCP_OFS_CMD, 32'h8000_2009);
        rdr(`SSLCP_OFS_CMD);
        chk(rd, 32'h0, "ignored write took effect");
        $display("test parameters done");
        wr(`SSLCP_OFS_CMD, 32'h0000_09FF);
        poll();
        chk(32'(chanRunning), 32'h0F, "running after start");
        rdr(`SSLCP_OFS_DATA);
        chk(rd, 32'h0000_00F0, "start fail mask");
        wr(`SSLCP_OFS_CMD, 32'h0000_10FF);
        poll();
        rdr(`SSLCP_OFS_DATA);
        chk(rd, 32'h0000_00F2, "exchange fail mask");
        chk(32'(xchgCnt), 32'h1, "exchange pulse count");
        chk(32'(lastMask), 32'hFF, "exchange channel mask");
        wr(`SSLCP_OFS_CMD, 32'h0000_0801);
        poll();
        chk(32'(chanRunning), 32'h0E, "per-channel stop");
        $display("test channels done");
        wr(`SSLCP_OFS_CMD, 32'h0000_4000);
        chk(32'(romLoadEn), 32'h1, "load enable while busy");
        poll();
        chk({romLoadEn, 31'(cpuCnt)}, 32'h1, "processor reset pulse");
        wr(`SSLCP_OFS_CMD, 32'h0000_1001);
        wr(`SSLCP_OFS_CMD, 32'(`SSLCP_GLOBAL_HALT));
        poll();
        chk(32'(linkCnt), 32'h1, "halt accepted while busy");
        chk(32'(chanRunning), 32'h0, "halt stops all channels");
        wr(`SSLCP_OFS_CMD, 32'h0000_0FFF);
        poll();
        chk(32'(chanSetup), 32'hFF, "setup start");
        $display("test control done");
        results();
    end
endmodule
